// ---- src/ctr_pkg.sv ----
// Constants and types shared by the control timeout recovery block.
package ctr_pkg;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TENTH_SEC_NS  = 100_000_000;
   localparam int unsigned TENTH_CYCLES  = TENTH_SEC_NS / CLK_PERIOD_NS;
   localparam int unsigned PRESC_W       = 22;

   // ==========================================================================
   // Supervision interval, in tenths of a second
   // ==========================================================================
   localparam int unsigned IVL_W         = 18;
   localparam logic [17:0] IVL_MIN       = 18'h0000a;
   localparam logic [17:0] IVL_MAX       = 18'h2bf20;
   localparam logic [17:0] IVL_RESET     = 18'h00258;

   // ==========================================================================
   // Timeout action codes
   // ==========================================================================
   localparam int unsigned FUNC_W        = 5;
   localparam logic [4:0]  FUNC_OFF      = 5'h00;
   localparam logic [4:0]  FUNC_SETUP1   = 5'h07;
   localparam logic [4:0]  FUNC_SETUP4   = 5'h0a;

   // ==========================================================================
   // Setting codes and reset values
   // ==========================================================================
   localparam logic       END_HOLD       = 1'h0;
   localparam logic       END_RESUME     = 1'h1;
   localparam logic       END_RESET      = END_RESUME;
   localparam logic       RST_CMD_IDLE   = 1'h0;
   localparam logic       RST_CMD_DO     = 1'h1;
   localparam logic [1:0] DIAG_DISABLE   = 2'h0;
   localparam logic [1:0] DIAG_ALARM_WARN = 2'h2;
   localparam int unsigned PROF_W        = 3;
   localparam logic [2:0] PROF_NATIVE    = 3'h0;
   localparam logic [1:0] SETUP_RESET    = 2'h0;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [2:0] {
      ST_NORMAL  = 3'h1,
      ST_TIMEOUT = 3'h2,
      ST_HOLD    = 3'h4
   } ctr_state_e;

   typedef struct packed {
      logic       fixed;
      logic [1:0] num;
   } ctr_setup_s;

endpackage

// ---- src/ctr_recovery.sv ----
// Control word supervision with recovery of the setup after a timeout.

// Functional notes
// R01: No control word in interval raises timeout; here supervised_var_in also restarts it.
// R02: Interval 1 to 18000 s, tenths, default 60.
// R03: First valid word after timeout evaluates end action.
// R04: End action applies only to fixed setups.
// R05: Code 0 holds setup with warning until reset; here writing code 1 during the hold also ends it.
// R06: Code 1 resumes earlier setup on valid word.
// R07: Reset command acts only under code 0.
// R08: Reset setting 0 keeps timeout fixed setup.
// R09: Writing 1 restores the original setup.
// R10: Reset setting clears itself after acting.
// R11: Diagnosis trigger takes 0..2, no effect here.
// R12: Profile selects word interpretation, default native; here it is only stored and read back.
// R13: Only profiles valid for slot A accepted.
// R14: Warning drops when original setup restored.
module ctr_recovery #(
   parameter int unsigned TENTH_CYCLES = ctr_pkg::TENTH_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        ctrl_word_valid_in,
   input  wire logic        supervised_var_in,
   input  wire logic        ivl_wr_in,
   input  wire logic [17:0] ivl_data_in,
   input  wire logic [4:0]  timeout_func_in,
   input  wire logic        end_action_wr_in,
   input  wire logic        end_action_data_in,
   input  wire logic        reset_cmd_wr_in,
   input  wire logic        reset_cmd_data_in,
   input  wire logic        diag_wr_in,
   input  wire logic [1:0]  diag_data_in,
   input  wire logic        profile_wr_in,
   input  wire logic [2:0]  profile_data_in,
   input  wire logic [7:0]  slot_a_profile_mask_in,
   input  wire logic [1:0]  user_setup_in,
   output logic             timeout_out,
   output logic             timeout_event_out,
   output logic [4:0]       timeout_action_out,
   output logic [1:0]       active_setup_out,
   output logic             hold_warning_out,
   output logic [17:0]      ivl_out,
   output logic             end_action_out,
   output logic             reset_cmd_out,
   output logic [1:0]       diag_trigger_out,
   output logic [2:0]       profile_out
);

   // ==========================================================================
   // Decoding
   // ==========================================================================
   function automatic logic is_fixed_setup(input logic [4:0] func);
      is_fixed_setup = (func >= ctr_pkg::FUNC_SETUP1) &&
                       (func <= ctr_pkg::FUNC_SETUP4);
   endfunction

   function automatic logic [1:0] setup_of(input logic [4:0] func);
      logic [4:0] offs;
      offs     = func - ctr_pkg::FUNC_SETUP1;
      setup_of = offs[1:0];
   endfunction

   function automatic logic [17:0] clamp_ivl(input logic [17:0] v);
      if (v < ctr_pkg::IVL_MIN) begin
         clamp_ivl = ctr_pkg::IVL_MIN;
      end else if (v > ctr_pkg::IVL_MAX) begin
         clamp_ivl = ctr_pkg::IVL_MAX;
      end else begin
         clamp_ivl = v;
      end
   endfunction

   // ==========================================================================
   // Settings
   // ==========================================================================
   logic [17:0] ivl_ff;
   logic [17:0] nxt_ivl;
   logic        end_action_ff;
   logic        nxt_end_action;
   logic [1:0]  diag_ff;
   logic [1:0]  nxt_diag;
   logic [2:0]  profile_ff;
   logic [2:0]  nxt_profile;

   always_comb begin
      nxt_ivl        = ivl_ff;
      nxt_end_action = end_action_ff;
      nxt_diag       = diag_ff;
      nxt_profile    = profile_ff;
      // Out-of-range intervals are clamped, not refused, so a stray write
      // can never switch supervision off.
      if (ivl_wr_in) begin
         nxt_ivl = clamp_ivl(ivl_data_in); // R02
      end
      if (end_action_wr_in) begin
         nxt_end_action = end_action_data_in;
      end
      // Codes beyond the documented set are dropped so the readback stays
      // legal. The trigger itself drives nothing on this network.
      if (diag_wr_in && (diag_data_in <= ctr_pkg::DIAG_ALARM_WARN)) begin
         nxt_diag = diag_data_in; // R11
      end
      if (profile_wr_in && slot_a_profile_mask_in[profile_data_in]) begin
         nxt_profile = profile_data_in; // R13
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ivl_ff        <= ctr_pkg::IVL_RESET;
         end_action_ff <= ctr_pkg::END_RESET;
         diag_ff       <= ctr_pkg::DIAG_DISABLE;
         profile_ff    <= ctr_pkg::PROF_NATIVE; // R12
      end else begin
         ivl_ff        <= nxt_ivl;
         end_action_ff <= nxt_end_action;
         diag_ff       <= nxt_diag;
         profile_ff    <= nxt_profile;
      end
   end

   // ==========================================================================
   // Supervision timer
   // ==========================================================================
   localparam logic [21:0] PRESC_LAST = 22'(TENTH_CYCLES - 1);

   // The recovery state is declared here since the timer is held at zero outside ST_NORMAL.
   ctr_pkg::ctr_state_e state_ff;
   ctr_pkg::ctr_state_e nxt_state;

   logic [21:0] presc_ff;
   logic [21:0] nxt_presc;
   logic [17:0] tenths_ff;
   logic [17:0] nxt_tenths;
   logic        expire;
   logic        refresh;

   assign refresh = ctrl_word_valid_in | supervised_var_in;

   always_comb begin
      nxt_presc  = presc_ff;
      nxt_tenths = tenths_ff;
      expire     = 1'b0;
      if (refresh || (state_ff != ctr_pkg::ST_NORMAL)) begin
         nxt_presc  = '0;
         nxt_tenths = '0;
      end else if (presc_ff == PRESC_LAST) begin
         nxt_presc = '0;
         if ((tenths_ff + 18'h00001) >= ivl_ff) begin
            expire     = 1'b1; // R01
            nxt_tenths = '0;
         end else begin
            nxt_tenths = tenths_ff + 18'h00001;
         end
      end else begin
         nxt_presc = presc_ff + 22'h000001;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         presc_ff  <= '0;
         tenths_ff <= '0;
      end else begin
         presc_ff  <= nxt_presc;
         tenths_ff <= nxt_tenths;
      end
   end

   // ==========================================================================
   // Recovery state machine
   // ==========================================================================
   ctr_pkg::ctr_setup_s fix_ff;
   ctr_pkg::ctr_setup_s nxt_fix;
   logic [1:0]          setup_ff;
   logic [1:0]          nxt_setup;
   logic                warn_ff;
   logic                nxt_warn;
   logic                rst_cmd_ff;
   logic                nxt_rst_cmd;
   logic                tmo_ff;
   logic                nxt_tmo;
   logic                evt_ff;
   logic                nxt_evt;
   logic [4:0]          act_ff;
   logic [4:0]          nxt_act;
   logic                do_reset;

   // The command is held one cycle so it can be read back before it clears.
   // A write under resume mode is stored and cleared but moves no setup.
   assign do_reset = (rst_cmd_ff == ctr_pkg::RST_CMD_DO) &&
                     (end_action_ff == ctr_pkg::END_HOLD) && fix_ff.fixed;

   always_comb begin
      nxt_state   = state_ff;
      nxt_fix     = fix_ff;
      nxt_setup   = setup_ff;
      nxt_warn    = warn_ff;
      nxt_tmo     = tmo_ff;
      nxt_evt     = 1'b0;
      nxt_act     = act_ff;
      nxt_rst_cmd = ctr_pkg::RST_CMD_IDLE; // R10
      if (reset_cmd_wr_in) begin
         nxt_rst_cmd = reset_cmd_data_in;
      end
      case (state_ff)
         ctr_pkg::ST_NORMAL: begin
            nxt_setup = user_setup_in;
            if (expire) begin
               nxt_state = ctr_pkg::ST_TIMEOUT; // R01
               nxt_tmo   = 1'b1;
               nxt_evt   = 1'b1;
               nxt_act   = timeout_func_in;
               nxt_fix.fixed = is_fixed_setup(timeout_func_in);
               nxt_fix.num   = setup_of(timeout_func_in);
               if (is_fixed_setup(timeout_func_in)) begin
                  nxt_setup = nxt_fix.num;
               end
            end
         end
         ctr_pkg::ST_TIMEOUT: begin
            // A reset taken while still timed out restores the setup at
            // once; the returning word then ends the timeout with no warning.
            if (do_reset) begin
               nxt_fix.fixed = 1'b0; // R09
               nxt_setup     = user_setup_in;
            end
            if (ctrl_word_valid_in) begin // R03
               nxt_tmo = 1'b0;
               nxt_act = ctr_pkg::FUNC_OFF;
               if (!fix_ff.fixed || do_reset) begin
                  nxt_state = ctr_pkg::ST_NORMAL; // R04
                  nxt_setup = user_setup_in;
               end else if (end_action_ff == ctr_pkg::END_RESUME) begin
                  nxt_state = ctr_pkg::ST_NORMAL; // R06
                  nxt_setup = user_setup_in;
               end else begin
                  nxt_state = ctr_pkg::ST_HOLD; // R05
                  nxt_warn  = 1'b1;
               end
            end
         end
         ctr_pkg::ST_HOLD: begin
            if (do_reset) begin
               nxt_state     = ctr_pkg::ST_NORMAL; // R07
               nxt_fix.fixed = 1'b0;
               nxt_setup     = user_setup_in; // R09
               nxt_warn      = 1'b0; // R14
            end else if (end_action_ff == ctr_pkg::END_RESUME) begin
               nxt_state = ctr_pkg::ST_NORMAL; // R06
               nxt_setup = user_setup_in;
               nxt_warn  = 1'b0; // R14
            end else begin
               nxt_setup = fix_ff.num; // R08
            end
         end
         default: begin
            nxt_state = ctr_pkg::ST_NORMAL;
            nxt_warn  = 1'b0;
            nxt_tmo   = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff   <= ctr_pkg::ST_NORMAL;
         fix_ff     <= '0;
         setup_ff   <= ctr_pkg::SETUP_RESET;
         warn_ff    <= 1'b0;
         rst_cmd_ff <= ctr_pkg::RST_CMD_IDLE;
         tmo_ff     <= 1'b0;
         evt_ff     <= 1'b0;
         act_ff     <= ctr_pkg::FUNC_OFF;
      end else begin
         state_ff   <= nxt_state;
         fix_ff     <= nxt_fix;
         setup_ff   <= nxt_setup;
         warn_ff    <= nxt_warn;
         rst_cmd_ff <= nxt_rst_cmd;
         tmo_ff     <= nxt_tmo;
         evt_ff     <= nxt_evt;
         act_ff     <= nxt_act;
      end
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign timeout_out        = tmo_ff;
   assign timeout_event_out  = evt_ff;
   assign timeout_action_out = act_ff;
   assign active_setup_out   = setup_ff;
   assign hold_warning_out   = warn_ff;
   assign ivl_out            = ivl_ff;
   assign end_action_out     = end_action_ff;
   assign reset_cmd_out      = rst_cmd_ff;
   assign diag_trigger_out   = diag_ff;
   assign profile_out        = profile_ff;

endmodule

// ---- test/ctr_recovery_props.sv ----
// Assertion checker for the control timeout recovery block.
module ctr_recovery_props (
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic       ctrl_word_valid_in,
   input wire logic       reset_cmd_wr_in,
   input wire logic       reset_cmd_data_in,
   input wire logic       profile_wr_in,
   input wire logic [2:0] profile_data_in,
   input wire logic [7:0] slot_a_profile_mask_in,
   input wire logic [1:0] user_setup_in,
   input wire logic       timeout_out,
   input wire logic       timeout_event_out,
   input wire logic [4:0] timeout_action_out,
   input wire logic [1:0] active_setup_out,
   input wire logic       hold_warning_out,
   input wire logic       end_action_out,
   input wire logic       reset_cmd_out,
   input wire logic [1:0] diag_trigger_out,
   input wire logic [2:0] profile_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Helpers
   // ==========================================================================
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic fixed;
   assign fixed = timeout_action_out >= ctr_pkg::FUNC_SETUP1 &&
                  timeout_action_out <= ctr_pkg::FUNC_SETUP4;
   // A reset taken while still timed out ends the episode without a hold.
   logic early_ff;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         early_ff <= 1'b0;
      end else if (timeout_out && reset_cmd_out && !end_action_out) begin
         early_ff <= 1'b1;
      end else if (!timeout_out) begin
         early_ff <= 1'b0;
      end
   end
   sequence s_cmd;
      reset_cmd_wr_in && reset_cmd_data_in;
   endsequence
   sequence s_restored;
      !hold_warning_out && !reset_cmd_out && active_setup_out == user_setup_in;
   endsequence
   // ==========================================================================
   // Properties
   // ==========================================================================
   cmd_restore_a: assert property (hold_warning_out && !end_action_out ##0
      s_cmd |=> reset_cmd_out ##1 s_restored) else $error("no restore");
   cmd_oneshot_a: assert property (reset_cmd_out && !(reset_cmd_wr_in &&
      reset_cmd_data_in) |=> !reset_cmd_out) else $error("cmd stuck");
   event_rise_a: assert property ($rose(timeout_out) |->
      timeout_event_out ##1 !timeout_event_out) else $error("bad event");
   fixed_setup_a: assert property ($rose(timeout_out) && fixed |->
      active_setup_out == 2'(timeout_action_out - 5'h07)) else $error("setup");
   setup_resume_a: assert property (ctrl_word_valid_in &&
      timeout_out && fixed && end_action_out |=>
      active_setup_out == $past(user_setup_in) && !hold_warning_out)
      else $error("no resume");
   hold_set_a: assert property (ctrl_word_valid_in && timeout_out && fixed &&
      !end_action_out && !reset_cmd_out && !early_ff |=> hold_warning_out &&
      $stable(active_setup_out)) else $error("no hold");
   nonfixed_end_a: assert property (ctrl_word_valid_in && timeout_out &&
      !fixed |=> !timeout_out && !hold_warning_out) else $error("nonfixed");
   diag_range_a: assert property (diag_trigger_out <= ctr_pkg::DIAG_ALARM_WARN)
      else $error("diag range");
   prof_take_a: assert property (profile_wr_in &&
      slot_a_profile_mask_in[profile_data_in] |=>
      profile_out == $past(profile_data_in)) else $error("profile");
   warn_drop_a: assert property ($fell(hold_warning_out) |->
      active_setup_out == $past(user_setup_in)) else $error("warn drop");
endmodule

// ---- test/ctr_master_model.sv ----
// Fieldbus master model that sends one control word after a chosen gap.
module ctr_master_model (
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   input  wire logic       go_in,
   input  wire logic [7:0] gap_in,
   output logic            valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // A long gap models a slow master; the word is a single-cycle pulse.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= -1;
         valid_out <= 1'b0;
      end else begin
         cnt <= go_in ? int'(gap_in) : (cnt >= 0 ? cnt - 1 : -1);
         valid_out <= #1 (cnt == 0);
      end
   end
endmodule

// ---- test/test_ctr_recovery.sv ----
// Self-checking bench for the control timeout recovery block.
module test_ctr_recovery;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int W_IVL = 0, W_END = 1, W_RCMD = 2, W_DIAG = 3, W_PROF = 4;
   logic        clk_in, rst_n_in, ctrl_word_valid_in, supervised_var_in;
   logic        ivl_wr_in, end_action_wr_in, end_action_data_in, go;
   logic        reset_cmd_wr_in, reset_cmd_data_in, diag_wr_in;
   logic        profile_wr_in, timeout_out, timeout_event_out;
   logic        hold_warning_out, end_action_out, reset_cmd_out;
   logic [17:0] ivl_data_in, ivl_out;
   logic [4:0]  timeout_func_in, timeout_action_out;
   logic [2:0]  profile_data_in, profile_out;
   logic [1:0]  diag_data_in, user_setup_in, active_setup_out;
   logic [1:0]  diag_trigger_out;
   logic [7:0]  slot_a_profile_mask_in, gap;
   int          n_errors = 0, n_tests = 0;
   // ==========================================================================
   // Instances
   // ==========================================================================
   ctr_recovery #(.TENTH_CYCLES(4)) i_dut (.clk_in, .rst_n_in,
      .ctrl_word_valid_in, .supervised_var_in, .ivl_wr_in, .ivl_data_in,
      .timeout_func_in, .end_action_wr_in, .end_action_data_in,
      .reset_cmd_wr_in, .reset_cmd_data_in, .diag_wr_in, .diag_data_in,
      .profile_wr_in, .profile_data_in, .slot_a_profile_mask_in,
      .user_setup_in, .timeout_out, .timeout_event_out, .timeout_action_out,
      .active_setup_out, .hold_warning_out, .ivl_out, .end_action_out,
      .reset_cmd_out, .diag_trigger_out, .profile_out);
   ctr_master_model i_master (.clk_in, .rst_n_in, .go_in(go), .gap_in(gap),
      .valid_out(ctrl_word_valid_in));
   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input int sel, input logic [17:0] d);
      tick(1);
      ivl_data_in = d;
      end_action_data_in = d[0];
      reset_cmd_data_in = d[0];
      diag_data_in = d[1:0];
      profile_data_in = d[2:0];
      {ivl_wr_in, end_action_wr_in, reset_cmd_wr_in, diag_wr_in,
       profile_wr_in} = 5'h10 >> sel;
      tick(1);
      {ivl_wr_in, end_action_wr_in, reset_cmd_wr_in, diag_wr_in,
       profile_wr_in} = 5'h00;
   endtask
   task automatic word(input logic [7:0] g);
      gap = g;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      tick(int'(g) + 3);
   endtask
   task automatic wait_to();
      for (int i = 0; i < 100 && timeout_out !== 1'b1; i++)
         tick(1);
      if (timeout_out !== 1'b1) begin
         n_errors++;
         close_out();
      end
   endtask
   task automatic close_out();
      $display("Errors %0d, checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================================================
   // Stimulus
   // ==========================================================================
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   initial begin
      {rst_n_in, supervised_var_in, go, gap} = '0;
      {ivl_wr_in, end_action_wr_in, reset_cmd_wr_in, diag_wr_in} = '0;
      {profile_wr_in, ivl_data_in, end_action_data_in} = '0;
      {reset_cmd_data_in, diag_data_in, profile_data_in} = '0;
      user_setup_in = 2'h3;
      slot_a_profile_mask_in = 8'h05;
      timeout_func_in = 5'h08;
      tick(12);
      rst_n_in = 1'b1;
      tick(1);
      chk(ivl_out, ctr_pkg::IVL_RESET);
      chk(end_action_out, 18'h1);
      chk(reset_cmd_out, 18'h0);
      chk(diag_trigger_out, 18'h0);
      chk(profile_out, 18'h0);
      for (int d = 0; d < 4; d++) begin
         wr(W_DIAG, 18'(d));
         chk(diag_trigger_out, (d < 3) ? 18'(d) : 18'h2);
      end
      wr(W_PROF, 18'h2);
      chk(profile_out, 18'h2);
      wr(W_PROF, 18'h1);
      chk(profile_out, 18'h2);
      wr(W_PROF, 18'h0);
      chk(profile_out, 18'h0);
      word(8'h0);
      wr(W_IVL, 18'h3ffff);
      chk(ivl_out, ctr_pkg::IVL_MAX);
      wr(W_IVL, 18'h0);
      chk(ivl_out, ctr_pkg::IVL_MIN);
      repeat (6) begin
         supervised_var_in = 1'b1;
         tick(1);
         supervised_var_in = 1'b0;
         tick(30);
      end
      chk(timeout_out, 18'h0);
      wait_to();
      chk(timeout_event_out, 18'h1);
      chk(active_setup_out, 18'h1);
      chk(timeout_action_out, 18'h8);
      word(8'h0);
      chk(timeout_out, 18'h0);
      chk(active_setup_out, 18'h3);
      wr(W_END, 18'h0);
      wait_to();
      word(8'h14);
      chk(hold_warning_out, 18'h1);
      tick(60);
      chk(active_setup_out, 18'h1);
      wr(W_RCMD, 18'h1);
      chk(reset_cmd_out, 18'h1);
      tick(1);
      chk(reset_cmd_out, 18'h0);
      chk(active_setup_out, 18'h3);
      chk(hold_warning_out, 18'h0);
      timeout_func_in = 5'h02;
      wait_to();
      chk(active_setup_out, 18'h3);
      word(8'h0);
      chk(hold_warning_out, 18'h0);
      wr(W_END, 18'h1);
      timeout_func_in = 5'h09;
      wait_to();
      wr(W_RCMD, 18'h1);
      tick(1);
      chk(active_setup_out, 18'h2);
      word(8'h0);
      chk(active_setup_out, 18'h3);
      wr(W_END, 18'h0);
      timeout_func_in = 5'h07;
      wait_to();
      chk(active_setup_out, 18'h0);
      wr(W_RCMD, 18'h1);
      tick(1);
      chk(active_setup_out, 18'h3);
      chk(timeout_out, 18'h1);
      word(8'h0);
      chk(timeout_out, 18'h0);
      chk(hold_warning_out, 18'h0);
      user_setup_in = 2'h0;
      timeout_func_in = 5'h0a;
      wait_to();
      chk(active_setup_out, 18'h3);
      word(8'h0);
      chk(hold_warning_out, 18'h1);
      wr(W_END, 18'h1);
      tick(1);
      chk(active_setup_out, 18'h0);
      chk(hold_warning_out, 18'h0);
      close_out();
   end
endmodule
bind ctr_recovery ctr_recovery_props i_props (.clk_in, .rst_n_in,
   .ctrl_word_valid_in, .reset_cmd_wr_in, .reset_cmd_data_in,
   .profile_wr_in, .profile_data_in, .slot_a_profile_mask_in,
   .user_setup_in, .timeout_out, .timeout_event_out, .timeout_action_out,
   .active_setup_out, .hold_warning_out, .end_action_out, .reset_cmd_out,
   .diag_trigger_out, .profile_out);
